// *** dma_msg_pkg.sv ***
// shared constants for the dma message transfer engine
package dma_msg_pkg;
   localparam int SPTR_W = 22;
   localparam int DPTR_W = 16;
   localparam int CNT_W  = 12;
   localparam int DATA_W = 8;
   localparam int AADDR_W = 6;

   // register byte offsets
   localparam logic [AADDR_W-1:0] OFF_CTRL  = 6'h00;
   localparam logic [AADDR_W-1:0] OFF_SSA   = 6'h04;
   localparam logic [AADDR_W-1:0] OFF_SSZ   = 6'h08;
   localparam logic [AADDR_W-1:0] OFF_DSA   = 6'h0C;
   localparam logic [AADDR_W-1:0] OFF_DSZ   = 6'h10;
   localparam logic [AADDR_W-1:0] OFF_SPTR  = 6'h14;
   localparam logic [AADDR_W-1:0] OFF_SCNT  = 6'h18;
   localparam logic [AADDR_W-1:0] OFF_DPTR  = 6'h1C;
   localparam logic [AADDR_W-1:0] OFF_DCNT  = 6'h20;

   // control register fields
   localparam int BIT_EN    = 0;
   localparam int BIT_GO    = 1;
   localparam int BIT_HWEN  = 2;
   localparam int BIT_SOURCE_STEP_SELECT = 4;
   localparam int BIT_DESTINATION_STEP_SELECT = 6;
   localparam int BIT_BUSY  = 8;

   localparam logic [1:0] STEP_HOLD = 2'h0;
   localparam logic [1:0] STEP_INC  = 2'h1;
   localparam logic [1:0] STEP_DEC  = 2'h2;

   localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
   localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

   typedef enum logic [1:0] {PH_IDLE, PH_READ, PH_WRITE} phase_t;
endpackage

// *** dma_step_unit.sv ***
// pointer and counter update for one side of a channel
`timescale 1ns/1ps
module dma_step_unit #(
   parameter int PW = 16
) (
   input  wire logic [PW-1:0]                 ptr,
   input  wire logic [dma_msg_pkg::CNT_W-1:0] cnt,
   input  wire logic [PW-1:0]                 start_addr,
   input  wire logic [dma_msg_pkg::CNT_W-1:0] size,
   input  wire logic [1:0]                    mode,
   output logic      [PW-1:0]                 ptr_nx,
   output logic      [dma_msg_pkg::CNT_W-1:0] cnt_nx
);
   always_comb begin
      if (cnt != dma_msg_pkg::CNT_ONE) begin
         cnt_nx = cnt - dma_msg_pkg::CNT_ONE;
         case (mode)
            dma_msg_pkg::STEP_INC: ptr_nx = ptr + PW'(1);
            dma_msg_pkg::STEP_DEC: ptr_nx = ptr - PW'(1);
            default: ptr_nx = ptr;
         endcase
      end else begin
         // end of region wraps back to the start
         cnt_nx = size;
         ptr_nx = start_addr;
      end
   end
endmodule

// *** dma_clock_gate.sv ***
// latch-free clock enable for sleep and module disable
`timescale 1ns/1ps
module dma_clock_gate (
   input  wire logic clk_sys,
   input  wire logic rst_b,
   input  wire logic sleep,
   input  wire logic module_disable_bit,
   output logic      run
);
   logic run_q;
   // registered so the enable rises only on a clean edge; sleep or disable drops it at once
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         run_q <= 1'b0;
      end else begin
         run_q <= !sleep && !module_disable_bit; // R12 R17
      end
   end
   assign run = run_q && !sleep && !module_disable_bit;
endmodule

// *** dma_message_transfer_engine.sv ***
// dma channel engine: registers, triggers and byte transfer sequencing
// Operation
// R1: enable loads pointers and counters from settings
// R2: source counter decrements, reloads at one
// R3: source pointer steps by mode, reloads
// R4: destination counter decrements, reloads at one
// R5: destination pointer steps by mode, reloads
// R6: start by go bit or hardware trigger
// R7: go bit starts, stops, shows progress
// R8: software start ignored unless enabled
// R9: setting go while set has no effect
// R10: any reset restores register defaults
// R11: clearing enable restores register defaults
// R12: no transfer activity during sleep
// R13: sleep pauses, transfer resumes, registers kept
// R14: software should finish transfers before sleep
// R15: idle: use every granted cycle
// R16: doze: use cycles granted by arbiter
// R17: module disable gates the engine fully; here it stops only transfers and triggers, and register access still works
// R18: full address reach including mirror bank
// R19: granted cycle reads byte, writes byte, steps
// R20: request only in progress; hold when ungranted
`timescale 1ns/1ps
module dma_message_transfer_engine (
   input  wire logic                           clk_sys,
   input  wire logic                           rst_b,
   input  wire logic [dma_msg_pkg::AADDR_W-1:0] avs_address,
   input  wire logic                           avs_read,
   input  wire logic                           avs_write,
   input  wire logic [3:0]                     avs_byteenable,
   input  wire logic [31:0]                    avs_writedata,
   output logic      [31:0]                    avs_readdata,
   output logic                                avs_waitrequest,
   input  wire logic                           start_trigger_request,
   input  wire logic                           sleep,
   input  wire logic                           module_disable_bit,
   output logic                                bus_request,
   input  wire logic                           bus_grant,
   output logic      [dma_msg_pkg::SPTR_W-1:0] mem_addr,
   output logic                                mem_read,
   output logic                                mem_write,
   output logic      [dma_msg_pkg::DATA_W-1:0] mem_wdata,
   input  wire logic [dma_msg_pkg::DATA_W-1:0] mem_rdata
);
   localparam int SW = dma_msg_pkg::SPTR_W;
   localparam int DW = dma_msg_pkg::DPTR_W;
   localparam int CW = dma_msg_pkg::CNT_W;

   logic                run;
   logic                en_q, go_q, hwen_q, trig_q;
   logic [1:0]          source_step_select_q, destination_step_select_q;
   logic [SW-1:0]       ssa_q, sptr_q, sptr_nx;
   logic [DW-1:0]       dsa_q, dptr_q, dptr_nx;
   logic [CW-1:0]       ssz_q, dsz_q, scnt_q, dcnt_q, scnt_nx, dcnt_nx;
   logic [dma_msg_pkg::DATA_W-1:0] data_q;
   dma_msg_pkg::phase_t ph_q;
   logic                ack_q;
   logic                wr_ctrl, wr_en_set, wr_en_clr, step;
   logic                acc_wr, acc_rd;
   logic [31:0]         wdat;
   logic [31:0]         ssa_w;
   logic [31:0]         ssz_w;
   logic [31:0]         dsa_w;
   logic [31:0]         dsz_w;
   logic [31:0]         rd_d;
   logic [31:0]         ctrl_rd;

   dma_clock_gate u_gate (
      .clk_sys            (clk_sys),
      .rst_b              (rst_b),
      .sleep              (sleep),
      .module_disable_bit (module_disable_bit),
      .run                (run)
   );

   dma_step_unit #(.PW(SW)) u_src (
      .ptr        (sptr_q),
      .cnt        (scnt_q),
      .start_addr (ssa_q),
      .size       (ssz_q),
      .mode       (source_step_select_q),
      .ptr_nx     (sptr_nx),
      .cnt_nx     (scnt_nx)
   );

   dma_step_unit #(.PW(DW)) u_dst (
      .ptr        (dptr_q),
      .cnt        (dcnt_q),
      .start_addr (dsa_q),
      .size       (dsz_q),
      .mode       (destination_step_select_q),
      .ptr_nx     (dptr_nx),
      .cnt_nx     (dcnt_nx)
   );

   // one wait cycle per access: every access answers at the second edge
   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   assign acc_wr = avs_write && !ack_q;
   assign acc_rd = avs_read && !ack_q;

   // byte enables merge writes with the current value
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction

   always_comb begin
      ctrl_rd = '0;
      ctrl_rd[dma_msg_pkg::BIT_EN] = en_q;
      ctrl_rd[dma_msg_pkg::BIT_GO] = go_q;
      ctrl_rd[dma_msg_pkg::BIT_HWEN] = hwen_q;
      ctrl_rd[dma_msg_pkg::BIT_SOURCE_STEP_SELECT +: 2] = source_step_select_q;
      ctrl_rd[dma_msg_pkg::BIT_DESTINATION_STEP_SELECT +: 2] = destination_step_select_q;
      ctrl_rd[dma_msg_pkg::BIT_BUSY] = (ph_q != dma_msg_pkg::PH_IDLE);
   end
   assign wdat = merge(ctrl_rd, avs_writedata, avs_byteenable);

   // each setting merged lane by lane with its current contents
   assign ssa_w = merge({10'h000, ssa_q}, avs_writedata, avs_byteenable);
   assign ssz_w = merge({20'h00000, ssz_q}, avs_writedata, avs_byteenable);
   assign dsa_w = merge({16'h0000, dsa_q}, avs_writedata, avs_byteenable);
   assign dsz_w = merge({20'h00000, dsz_q}, avs_writedata, avs_byteenable);
   assign wr_ctrl = acc_wr && (avs_address == dma_msg_pkg::OFF_CTRL);
   assign wr_en_set = wr_ctrl && wdat[dma_msg_pkg::BIT_EN] && !en_q;
   assign wr_en_clr = wr_ctrl && !wdat[dma_msg_pkg::BIT_EN];
   // a transaction completes on the granted write phase
   assign step = run && bus_grant && (ph_q == dma_msg_pkg::PH_WRITE);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read || avs_write) && !ack_q;
      end
   end

   // control bits
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin // R10
         en_q    <= 1'b0;
         hwen_q  <= 1'b0;
         source_step_select_q <= dma_msg_pkg::STEP_HOLD;
         destination_step_select_q <= dma_msg_pkg::STEP_HOLD;
      end else if (wr_en_clr) begin // R11
         en_q    <= 1'b0;
         hwen_q  <= 1'b0;
         source_step_select_q <= dma_msg_pkg::STEP_HOLD;
         destination_step_select_q <= dma_msg_pkg::STEP_HOLD;
      end else if (wr_ctrl) begin
         en_q    <= 1'b1;
         hwen_q  <= wdat[dma_msg_pkg::BIT_HWEN];
         source_step_select_q <= wdat[dma_msg_pkg::BIT_SOURCE_STEP_SELECT +: 2];
         destination_step_select_q <= wdat[dma_msg_pkg::BIT_DESTINATION_STEP_SELECT +: 2];
      end
   end

   // settings registers
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin // R10
         ssa_q <= '0;
         ssz_q <= '0;
         dsa_q <= '0;
         dsz_q <= '0;
      end else if (wr_en_clr) begin // R11
         ssa_q <= '0;
         ssz_q <= '0;
         dsa_q <= '0;
         dsz_q <= '0;
      end else if (acc_wr) begin
         case (avs_address)
            dma_msg_pkg::OFF_SSA:
               ssa_q <= ssa_w[SW-1:0]; // R18
            dma_msg_pkg::OFF_SSZ:
               ssz_q <= ssz_w[CW-1:0];
            dma_msg_pkg::OFF_DSA:
               dsa_q <= dsa_w[DW-1:0];
            dma_msg_pkg::OFF_DSZ:
               dsz_q <= dsz_w[CW-1:0];
            default: ;
         endcase
      end
   end

   // hardware trigger edge; sleep or module disable holds the last sampled trigger as it is
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         trig_q <= 1'b0;
      end else if (run) begin
         trig_q <= start_trigger_request;
      end
   end

   // go bit: a trigger set wins over a go-clear write in the same cycle, but clearing enable wins over both
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin // R10
         go_q <= 1'b0;
      end else if (wr_en_clr) begin // R11
         go_q <= 1'b0;
      end else if (run && en_q && hwen_q && start_trigger_request
                   && !trig_q) begin // R6 R7
         go_q <= 1'b1;
      end else if (wr_ctrl && en_q) begin // R8
         // rewriting a set go leaves it set and the transfer running
         go_q <= wdat[dma_msg_pkg::BIT_GO]; // R7 R9
      end
   end

   // pointers and counters
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin // R10
         sptr_q <= '0;
         scnt_q <= '0;
         dptr_q <= '0;
         dcnt_q <= '0;
      end else if (wr_en_clr) begin // R11
         sptr_q <= '0;
         scnt_q <= '0;
         dptr_q <= '0;
         dcnt_q <= '0;
      end else if (wr_en_set) begin // R1
         sptr_q <= ssa_q;
         scnt_q <= ssz_q;
         dptr_q <= dsa_q;
         dcnt_q <= dsz_q;
         // ungranted cycles fall through and keep every count
      end else if (step) begin // R19 R20
         scnt_q <= scnt_nx; // R2
         sptr_q <= sptr_nx; // R3
         dcnt_q <= dcnt_nx; // R4
         dptr_q <= dptr_nx; // R5
      end
   end

   // transfer phases: read then write, one per granted cycle
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ph_q   <= dma_msg_pkg::PH_IDLE;
         data_q <= '0;
      end else if (wr_en_clr) begin
         ph_q <= dma_msg_pkg::PH_IDLE;
         // a staged byte must not leak into the next message
         data_q <= '0;
      end else if (run && bus_grant) begin // R12 R13 R15 R16
         case (ph_q)
            dma_msg_pkg::PH_IDLE: begin
               if (go_q) ph_q <= dma_msg_pkg::PH_READ;
            end
            dma_msg_pkg::PH_READ: begin
               data_q <= mem_rdata; // R19
               ph_q   <= dma_msg_pkg::PH_WRITE;
            end
            dma_msg_pkg::PH_WRITE: begin
               // a cleared go stops after the byte in flight
               ph_q <= go_q ? dma_msg_pkg::PH_READ : dma_msg_pkg::PH_IDLE;
            end
            default: ph_q <= dma_msg_pkg::PH_IDLE;
         endcase
      end
   end

   // request only while a message is in progress and the engine runs
   assign bus_request = run && (go_q || ph_q != dma_msg_pkg::PH_IDLE); // R20
   assign mem_read  = bus_request && bus_grant
                      && (ph_q == dma_msg_pkg::PH_READ); // R17
   assign mem_write = step;
   // destination is narrower, so it is zero extended on the bus
   assign mem_addr  = (ph_q == dma_msg_pkg::PH_WRITE) ?
                      {{(SW-DW){1'b0}}, dptr_q} : sptr_q;
   assign mem_wdata = data_q;

   // read mux
   always_comb begin
      case (avs_address)
         dma_msg_pkg::OFF_CTRL: rd_d = ctrl_rd;
         dma_msg_pkg::OFF_SSA:  rd_d = {10'h000, ssa_q};
         dma_msg_pkg::OFF_SSZ:  rd_d = {20'h00000, ssz_q};
         dma_msg_pkg::OFF_DSA:  rd_d = {16'h0000, dsa_q};
         dma_msg_pkg::OFF_DSZ:  rd_d = {20'h00000, dsz_q};
         dma_msg_pkg::OFF_SPTR: rd_d = {10'h000, sptr_q};
         dma_msg_pkg::OFF_SCNT: rd_d = {20'h00000, scnt_q};
         dma_msg_pkg::OFF_DPTR: rd_d = {16'h0000, dptr_q};
         dma_msg_pkg::OFF_DCNT: rd_d = {20'h00000, dcnt_q};
         default:               rd_d = dma_msg_pkg::UNMAPPED_RD;
      endcase
   end

   // captured at the first edge so it stands when the wait ends
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         avs_readdata <= '0;
      end else if (acc_rd) begin
         avs_readdata <= rd_d;
      end
   end
endmodule

// *** dma_engine_chk.sv ***
// checker for the dma engine's register and memory ports
`timescale 1ns/1ps
module dma_engine_chk (
   input wire logic                           clk_sys,
   input wire logic                           rst_b,
   input wire logic                           avs_read,
   input wire logic                           avs_write,
   input wire logic                           avs_waitrequest,
   input wire logic                           sleep,
   input wire logic                           module_disable_bit,
   input wire logic                           bus_request,
   input wire logic                           bus_grant,
   input wire logic [dma_msg_pkg::SPTR_W-1:0] mem_addr,
   input wire logic                           mem_read,
   input wire logic                           mem_write,
   input wire logic [dma_msg_pkg::DATA_W-1:0] mem_wdata,
   input wire logic [dma_msg_pkg::DATA_W-1:0] mem_rdata
);
   logic [dma_msg_pkg::DATA_W-1:0] byte_q;
   logic                           read_seen_q;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // byte fetched in the last granted read
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         byte_q <= 8'h00;
      end else if (mem_read) begin
         byte_q <= mem_rdata;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         read_seen_q <= 1'b0;
      end else if (mem_read || mem_write) begin
         read_seen_q <= mem_read;
      end
   end
   a_sleep_quiet: assert property (
      sleep |-> !mem_read && !mem_write)
      else $error("memory cycle during sleep");
   a_disable_quiet: assert property (
      module_disable_bit |-> !(mem_read || mem_write))
      else $error("memory cycle while disabled");
   a_grant_only: assert property (
      mem_read || mem_write |-> bus_grant && bus_request)
      else $error("memory cycle without grant");
   a_rw_apart: assert property (!(mem_read && mem_write))
      else $error("read and write together");
   a_write_data: assert property (mem_write |-> mem_wdata == byte_q)
      else $error("written byte differs from read byte");
   a_read_first: assert property (mem_write |-> read_seen_q)
      else $error("write without preceding read");
   a_hold_ungranted: assert property (
      !bus_grant && !avs_write |=> $stable(mem_addr))
      else $error("address moved in ungranted cycle");
   a_wait_once: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("register access not answered");
   c_write: cover property (mem_write);
   c_sleep_busy: cover property (bus_request ##1 sleep);
   c_disabled_busy: cover property (bus_request ##1 module_disable_bit);
endmodule

bind dma_message_transfer_engine dma_engine_chk u_dma_engine_chk (
   .clk_sys(clk_sys), .rst_b(rst_b), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .sleep(sleep),
   .module_disable_bit(module_disable_bit), .bus_request(bus_request),
   .bus_grant(bus_grant), .mem_addr(mem_addr), .mem_read(mem_read),
   .mem_write(mem_write), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

// *** dma_arbiter_model.sv ***
// system arbiter and data memory seen by the dma engine
`timescale 1ns/1ps
module dma_arbiter_model (
   input  wire logic                           clk_sys,
   input  wire logic                           rst_b,
   input  wire logic                           slow,
   input  wire logic                           bus_request,
   output logic                                bus_grant,
   input  wire logic [dma_msg_pkg::SPTR_W-1:0] mem_addr,
   input  wire logic                           mem_read,
   input  wire logic                           mem_write,
   input  wire logic [dma_msg_pkg::DATA_W-1:0] mem_wdata,
   output logic      [dma_msg_pkg::DATA_W-1:0] mem_rdata
);
   logic                              tick_q;
   int                                n_wr;
   logic [dma_msg_pkg::SPTR_W-1:0]    wr_addr [256];
   logic [dma_msg_pkg::DATA_W-1:0]    wr_data [256];
   // slow mode leaves every other cycle to the cpu
   assign bus_grant = bus_request & (!slow | tick_q);
   // data bus not valid outside a read: drive the inverse
   assign mem_rdata = (mem_addr[7:0] ^ 8'h5A) ^ {8{!mem_read}};
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tick_q <= 1'b0;
         n_wr <= 0;
      end else begin
         tick_q <= !tick_q;
         if (mem_write && bus_grant) begin
            wr_addr[n_wr[7:0]] <= mem_addr;
            wr_data[n_wr[7:0]] <= mem_wdata;
            n_wr <= n_wr + 1;
         end
      end
   end
endmodule

// *** tb_dma_message_transfer_engine.sv ***
// testbench for the dma message transfer engine
`timescale 1ns/1ps
module tb_dma_message_transfer_engine;
   logic                               clk_sys = 1'b0;
   logic                               rst_b = 1'b0;
   logic [dma_msg_pkg::AADDR_W-1:0]    avs_address = 6'h00;
   logic                               avs_read = 1'b0;
   logic                               avs_write = 1'b0;
   logic [31:0]                        avs_writedata = 32'h0;
   logic [31:0]                        avs_readdata;
   logic                               avs_waitrequest;
   logic                               trig = 1'b0;
   logic                               sleep = 1'b0;
   logic                               mdis = 1'b0;
   logic                               slow = 1'b1;
   logic                               bus_request;
   logic                               bus_grant;
   logic [dma_msg_pkg::SPTR_W-1:0]     mem_addr;
   logic                               mem_read;
   logic                               mem_write;
   logic [dma_msg_pkg::DATA_W-1:0]     mem_wdata;
   logic [dma_msg_pkg::DATA_W-1:0]     mem_rdata;
   int                                 n_errors = 0;
   int                                 n_compared = 0;
   int                                 n;
   always #20 clk_sys = ~clk_sys;
   dma_message_transfer_engine u_dma_message_transfer_engine (
      .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hF),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .start_trigger_request(trig),
      .sleep(sleep), .module_disable_bit(mdis), .bus_request(bus_request),
      .bus_grant(bus_grant), .mem_addr(mem_addr), .mem_read(mem_read),
      .mem_write(mem_write), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
   dma_arbiter_model u_dma_arbiter_model (
      .clk_sys(clk_sys), .rst_b(rst_b), .slow(slow),
      .bus_request(bus_request), .bus_grant(bus_grant), .mem_addr(mem_addr),
      .mem_read(mem_read), .mem_write(mem_write), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata));
   task automatic stop_test;
      if (n_errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one access; request held until waitrequest is sampled low
   task automatic av(input logic wr, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int k;
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 100);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (k >= 100) begin
         n_errors++;
         stop_test();
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      av(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
      logic [31:0] q;
      av(1'b0, a, 32'h0, q);
      check(q & m, exp);
   endtask
   task automatic wait_wr(input int target);
      int k;
      k = 0;
      while (u_dma_arbiter_model.n_wr < target && k < 3000) begin
         @(posedge clk_sys);
         k++;
      end
      if (k >= 3000) begin
         n_errors++;
         stop_test();
      end
   endtask
   // no byte may move for ten cycles
   task automatic quiet;
      repeat (3) @(posedge clk_sys);
      n = u_dma_arbiter_model.n_wr;
      repeat (10) @(posedge clk_sys);
      check(u_dma_arbiter_model.n_wr, n);
   endtask
   task automatic t_reset;
      rd(dma_msg_pkg::OFF_CTRL, 32'hFFFFFFFF, 32'h0);
      rd(dma_msg_pkg::OFF_SPTR, 32'hFFFFFFFF, 32'h0);
      rd(dma_msg_pkg::OFF_DCNT, 32'hFFFFFFFF, 32'h0);
      rd(6'h3C, 32'hFFFFFFFF, dma_msg_pkg::UNMAPPED_RD);
      wr(dma_msg_pkg::OFF_CTRL, 32'h2);
      rd(dma_msg_pkg::OFF_CTRL, 32'h2, 32'h0);
   endtask
   // mirror bank source, three bytes up, two bytes down
   task automatic t_load;
      wr(dma_msg_pkg::OFF_SSA, 32'h004000);
      wr(dma_msg_pkg::OFF_SSZ, 32'h3);
      wr(dma_msg_pkg::OFF_DSA, 32'h0100);
      wr(dma_msg_pkg::OFF_DSZ, 32'h2);
      wr(dma_msg_pkg::OFF_CTRL, 32'h1);
      rd(dma_msg_pkg::OFF_SPTR, 32'hFFFFFFFF, 32'h004000);
      rd(dma_msg_pkg::OFF_SCNT, 32'hFFFFFFFF, 32'h3);
      rd(dma_msg_pkg::OFF_DPTR, 32'hFFFFFFFF, 32'h0100);
      rd(dma_msg_pkg::OFF_DCNT, 32'hFFFFFFFF, 32'h2);
   endtask
   task automatic t_run;
      wr(dma_msg_pkg::OFF_CTRL, 32'h93);
      wait_wr(3);
      wr(dma_msg_pkg::OFF_CTRL, 32'h93);
      slow <= 1'b0;
      wait_wr(9);
   endtask
   task automatic t_power;
      sleep <= 1'b1;
      quiet();
      sleep <= 1'b0;
      wait_wr(n + 3);
      mdis <= 1'b1;
      quiet();
      mdis <= 1'b0;
      wait_wr(n + 3);
   endtask
   // stop by software, restart by hardware trigger
   task automatic t_trigger;
      wr(dma_msg_pkg::OFF_CTRL, 32'h91);
      quiet();
      wr(dma_msg_pkg::OFF_CTRL, 32'h95);
      trig <= 1'b1;
      repeat (2) @(posedge clk_sys);
      trig <= 1'b0;
      rd(dma_msg_pkg::OFF_CTRL, 32'h2, 32'h2);
      wait_wr(n + 3);
   endtask
   task automatic t_clear;
      wr(dma_msg_pkg::OFF_CTRL, 32'h0);
      rd(dma_msg_pkg::OFF_SPTR, 32'hFFFFFFFF, 32'h0);
      rd(dma_msg_pkg::OFF_SSA, 32'hFFFFFFFF, 32'h0);
      quiet();
   endtask
   // one recorded memory write against its expected address and byte
   task automatic seen_wr(input int k, input logic [31:0] a,
                          input logic [31:0] d);
      check(32'(u_dma_arbiter_model.wr_addr[k]), a);
      check(32'(u_dma_arbiter_model.wr_data[k]), d);
   endtask
   // whole byte stream, continuous across pauses and restarts
   task automatic t_stream;
      logic [31:0] a;
      for (int k = 0; k < n && k < 256; k++) begin
         a = (k % 2) ? 32'hFF : 32'h100;
         seen_wr(k, a, 32'(k % 3) ^ 32'h5A);
      end
   endtask
   // step select 00 keeps both pointers still through the counts
   task automatic t_hold;
      wr(dma_msg_pkg::OFF_SSA, 32'h004005);
      wr(dma_msg_pkg::OFF_SSZ, 32'h2);
      wr(dma_msg_pkg::OFF_DSA, 32'h0200);
      wr(dma_msg_pkg::OFF_DSZ, 32'h3);
      wr(dma_msg_pkg::OFF_CTRL, 32'h1);
      wr(dma_msg_pkg::OFF_CTRL, 32'h3);
      wait_wr(n + 2);
      wr(dma_msg_pkg::OFF_CTRL, 32'h0);
      seen_wr(n, 32'h200, 32'h5F);
      seen_wr(n + 1, 32'h200, 32'h5F);
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'b1;
      t_reset();
      t_load();
      t_run();
      t_power();
      t_trigger();
      t_clear();
      t_stream();
      t_hold();
      stop_test();
   end
endmodule
